// ### dv/pcd_claim_decode_monitor.sv
// checker of claim timing at the claim decoder ports
`timescale 1ns/1ps
`default_nettype none
module pcd_claim_monitor (
  // clock and reset
  input wire logic              CLK,
  input wire logic              RESET,
  // apb handshake
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PREADY,
  // pci side
  input wire logic              FRAME_L,
  input wire logic              IRDY_L,
  input wire logic [3:0]        CBE_L,
  input wire logic              DEVSEL_L_I,
  input wire logic              DEVSEL_L_O,
  input wire logic              DEVSEL_L_OE,
  input wire pcd_pkg::pcd_hit_s HITS,
  // claim report
  input wire logic              CLAIMED,
  input wire logic              CLAIM_SUBTRACTIVE,
  input wire logic [1:0]        SUB_PATH
);
  import pcd_pkg::*;
  logic       busy_q;
  logic [3:0] cmd_q;
  logic [2:0] cyc_q;
  // own copy of the address phase; c/be changes in data phases
  always_ff @(posedge CLK) begin
    if (RESET) begin
      busy_q <= 1'b0;
      cmd_q  <= 4'h0;
      cyc_q  <= 3'h7;
    end else if (!busy_q && !FRAME_L) begin
      busy_q <= 1'b1;
      cmd_q  <= CBE_L;
      cyc_q  <= 3'h0;
    end else begin
      if (FRAME_L && IRDY_L) busy_q <= 1'b0;
      if (cyc_q != 3'h7) cyc_q <= cyc_q + 3'h1;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  property p_no_special; $fell(DEVSEL_L_O) |-> cmd_q != CMD_SPECIAL && (cyc_q == 3'h2 || cyc_q == 3'h4); endproperty
  a_no_special: assert property (p_no_special) else $error("claim on special cycle or off strobe");
  property p_kind; $rose(CLAIMED) |-> CLAIM_SUBTRACTIVE == (cyc_q == 3'h4); endproperty
  a_kind: assert property (p_kind) else $error("claim kind flag wrong");
  property p_sub; $fell(DEVSEL_L_O) && cyc_q == 3'h4 |-> !SUB_PATH[1] && cmd_q inside {4'h2, 4'h3, 4'h6, 4'h7, 4'hC, 4'hE, 4'hF}; endproperty
  a_sub: assert property (p_sub) else $error("bad subtractive claim");
  property p_int_ack; cyc_q == 3'h1 && cmd_q == CMD_INT_ACK && DEVSEL_L_I && !(FRAME_L && IRDY_L) |=> !DEVSEL_L_O; endproperty
  a_int_ack: assert property (p_int_ack) else $error("int ack not claimed");
  property p_legacy; cyc_q == 3'h1 && HITS.legacy_device_hit && cmd_q != CMD_SPECIAL && DEVSEL_L_I && !(FRAME_L && IRDY_L) |=> !DEVSEL_L_O; endproperty
  a_legacy: assert property (p_legacy) else $error("legacy hit not claimed");
  property p_hold; !DEVSEL_L_O && !(FRAME_L && IRDY_L) |=> !DEVSEL_L_O; endproperty
  a_hold: assert property (p_hold) else $error("claim dropped mid transfer");
  property p_release; !DEVSEL_L_O && FRAME_L && IRDY_L |=> DEVSEL_L_O && DEVSEL_L_OE ##1 !DEVSEL_L_OE; endproperty
  a_release: assert property (p_release) else $error("devsel release wrong");
  property p_oe; !DEVSEL_L_O |-> DEVSEL_L_OE && CLAIMED; endproperty
  a_oe: assert property (p_oe) else $error("devsel low undriven");
  // one wait state, single pulse
  property p_apb; PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY; endproperty
  a_apb: assert property (p_apb) else $error("apb ready timing wrong");
endmodule
bind pcd_claim_decode pcd_claim_monitor u_mon (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
  .PREADY(PREADY), .FRAME_L(FRAME_L), .IRDY_L(IRDY_L), .CBE_L(CBE_L), .DEVSEL_L_I(DEVSEL_L_I),
  .DEVSEL_L_O(DEVSEL_L_O), .DEVSEL_L_OE(DEVSEL_L_OE), .HITS(HITS), .CLAIMED(CLAIMED),
  .CLAIM_SUBTRACTIVE(CLAIM_SUBTRACTIVE), .SUB_PATH(SUB_PATH));
`default_nettype wire

// ### dv/pcd_host_model.sv
// host initiator model: one single-data-phase pci transfer per go
`timescale 1ns/1ps
`default_nettype none
module pcd_host_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // request from the bench
  input  wire logic        go,
  input  wire logic [3:0]  cmd,
  input  wire logic [31:0] addr,
  input  wire logic        idsel,
  // pci lines
  output logic             frame_l,
  output logic             irdy_l,
  output logic [31:0]      ad,
  output logic [3:0]       cbe_l,
  output logic             idsel_o,
  output logic             busy
);
  logic [2:0] ph_q;
  // 32-bit multiplexed ad; data phase puts int-ack code on c/be on purpose
  always_ff @(posedge clk) begin
    if (rst) begin
      ph_q    <= 3'h0;
      frame_l <= 1'b1;
      irdy_l  <= 1'b1;
      ad      <= 32'h0;
      cbe_l   <= 4'h0;
      idsel_o <= 1'b0;
      busy    <= 1'b0;
    end else if (go && !busy) begin
      ph_q    <= 3'h1;
      busy    <= 1'b1;
      frame_l <= 1'b0;
      ad      <= addr;
      cbe_l   <= cmd;
      idsel_o <= idsel;
    end else if (busy && ph_q != 3'h7) begin
      ph_q    <= ph_q + 3'h1;
      frame_l <= 1'b1;
      irdy_l  <= 1'b0;
      ad      <= ~ad;
      cbe_l   <= 4'h0;
      idsel_o <= 1'b0;
    end else begin
      // released lines keep toggling so stale values never look valid
      busy    <= 1'b0;
      irdy_l  <= 1'b1;
      ad      <= ~ad;
      cbe_l   <= ~cbe_l;
    end
  end
endmodule
`default_nettype wire

// ### dv/tb_pci_target_claim_decode.sv
// self-checking bench of the claim decoder
`timescale 1ns/1ps
`default_nettype none
module tb_pci_target_claim_decode;
  import pcd_pkg::*;
  logic CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, FRAME_L, IRDY_L, IDSEL, DEVSEL_L_I;
  logic DEVSEL_L_O, DEVSEL_L_OE, CLAIMED, CLAIM_SUBTRACTIVE, go, busy, other_l, id_r, er;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, AD, addr_r, rd, ctl, rom, q, r;
  logic [3:0]  CBE_L, cmd_r;
  logic [1:0]  SUB_PATH;
  pcd_hit_s    HITS;
  int          seed, err_count, n_compared, i, n_med, n_sub;
  // bus devsel is pulled up; another agent may pull it low
  assign DEVSEL_L_I = (DEVSEL_L_OE ? DEVSEL_L_O : 1'b1) & other_l;
  pcd_claim_decode DUT (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .FRAME_L(FRAME_L), .IRDY_L(IRDY_L), .AD(AD), .CBE_L(CBE_L), .IDSEL(IDSEL), .DEVSEL_L_I(DEVSEL_L_I),
    .DEVSEL_L_O(DEVSEL_L_O), .DEVSEL_L_OE(DEVSEL_L_OE), .HITS(HITS), .CLAIMED(CLAIMED),
    .CLAIM_SUBTRACTIVE(CLAIM_SUBTRACTIVE), .SUB_PATH(SUB_PATH));
  pcd_host_model u_host (.clk(CLK), .rst(RESET), .go(go), .cmd(cmd_r), .addr(addr_r), .idsel(id_r),
    .frame_l(FRAME_L), .irdy_l(IRDY_L), .ad(AD), .cbe_l(CBE_L), .idsel_o(IDSEL), .busy(busy));
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (n >= 20) begin
      err_count++;
      wrap_up();
    end
  endtask
  task automatic set_ctl(input logic [31:0] v);
    apb(1'b1, OFS_DECODE_CTRL, v);
    ctl = v & CTL_WMASK;
    @(posedge CLK);
    #1 chk({30'h0, SUB_PATH}, {30'h0, ctl[5:4]});
  endtask
  function automatic logic [1:0] exp_claim(input logic [3:0] c, input logic [31:0] a, input logic id,
                                           input pcd_hit_s h);
    logic cfg, mem, med;
    cfg = (c == CMD_CFG_RD || c == CMD_CFG_WR) && id && a[1:0] == 2'b00;
    mem = c inside {CMD_MEM_RD, CMD_MEM_WR, CMD_MEM_RDMUL, CMD_MEM_RDLN, CMD_MEM_WRINV};
    med = c == CMD_INT_ACK || h.legacy_device_hit || (h.dma_ctrl_hit && !ctl[0]) || (h.disk_ctrl_hit && !ctl[1])
      || (h.serial_bus_ctrl_hit && !ctl[2]) || (cfg && (a[10:8] == FN_0 || a[10:8] == FN_3
      || (a[10:8] == FN_1 && !ctl[1]) || (a[10:8] == FN_4 && !ctl[2])))
      || (mem && ((a[31:16] ^ rom[15:0]) & rom[31:16]) == 16'h0);
    if (c == CMD_SPECIAL) return 2'd0;
    if (med) return 2'd1;
    if ((mem || c == CMD_IO_RD || c == CMD_IO_WR) && !ctl[5]) return 2'd2;
    return 2'd0;
  endfunction
  task automatic xact(input logic [3:0] c, input logic [31:0] a, input logic id, input pcd_hit_s h,
                      input logic oth);
    logic [1:0] e;
    int n;
    e = oth ? 2'd0 : exp_claim(c, a, id, h);
    n = 0;
    if (e == 2'd1) n_med++;
    if (e == 2'd2) n_sub++;
    @(posedge CLK);
    go <= 1'b1;
    cmd_r <= c;
    addr_r <= a;
    id_r <= id;
    HITS <= h;
    other_l <= ~oth;
    @(posedge CLK);
    go <= 1'b0;
    repeat (3) @(posedge CLK);
    #1 chk({31'h0, ~DEVSEL_L_O}, {31'h0, e == 2'd1});
    repeat (2) @(posedge CLK);
    #1 chk({30'h0, ~DEVSEL_L_O, CLAIM_SUBTRACTIVE & CLAIMED}, {30'h0, e != 2'd0, e == 2'd2});
    while ((busy | DEVSEL_L_OE | ~IRDY_L) !== 1'b0 && n < 30) begin
      @(posedge CLK);
      n++;
    end
    if (n >= 30) begin
      err_count++;
      wrap_up();
    end
    other_l <= 1'b1;
  endtask
  initial begin
    seed = 40;
    err_count = 0;
    n_compared = 0;
    n_med = 0;
    n_sub = 0;
    {RESET, other_l} = 2'b11;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, go, cmd_r, addr_r, id_r, HITS} = '0;
    ctl = CTL_RESET;
    rom = ROM_RESET;
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    apb(1'b0, OFS_DECODE_CTRL, 32'h0);
    chk(rd, CTL_RESET);
    apb(1'b0, OFS_BOOT_ROM, 32'h0);
    chk(rd, ROM_RESET);
    apb(1'b1, 12'h010, 32'h5A);
    chk({31'h0, er}, 32'h1);
    set_ctl(32'hFFFF_FFFF);
    $display("test registers done");
    // every command code, every path select; legacy hit only with path select 1x
    for (i = 0; i < 64; i++) begin
      set_ctl({26'h0, i[5:4], 4'h0});
      xact(i[3:0], 32'h0000_0400, 1'b0, pcd_hit_s'({i[5], 3'b000}), 1'b0);
    end
    $display("test commands done");
    for (i = 0; i < 32; i++) begin
      set_ctl({29'h0, i[4:3], 1'b0});
      xact(CMD_CFG_RD, {21'h0, i[2:0], 8'h00}, 1'b1, '0, 1'b0);
    end
    $display("test config done");
    apb(1'b1, OFS_BOOT_ROM, 32'hFF00_1234);
    rom = 32'hFF00_1234;
    xact(CMD_MEM_RD, 32'h1299_0000, 1'b0, '0, 1'b0);
    for (i = 0; i < 150; i++) begin
      q = $random(seed);
      r = $random(seed);
      if (i % 4 == 0) set_ctl(q ^ r);
      xact(r[3:0], {q[4] ? 8'h12 : q[31:24], q[23:0]}, r[4], pcd_hit_s'(r[8:5]), r[11:9] == 3'h0);
    end
    $display("test random done");
    apb(1'b0, OFS_CLAIM_CNT, 32'h0);
    chk(rd, {n_sub[15:0], n_med[15:0]});
    apb(1'b1, OFS_CLAIM_CNT, 32'h0);
    apb(1'b0, OFS_CLAIM_CNT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'h9, 32'h0);
    $display("test counters done");
    wrap_up();
  end
endmodule
`default_nettype wire

// ### rtl/pcd_claim_decode.sv
// pci target claim decoder with apb register access
// Summary of operation
// - accepted target accesses get devsel, with medium or subtractive timing
// - never start a claim when the latched command is a special cycle
// - subtractive strobe claims io and memory commands unless path select is 1x
// - command codes 2,3,6,7,12,14,15 are io and memory read/write variants
// - c/be lines latched in address phase are the command for all decisions
// - medium strobe claims interrupt acknowledge and medium target hits if devsel idle
// - legacy device hits are claimed with medium timing
// - config cycles to own functions 0, 1, 3 and 4 are recognised
// - functions 0,3 always; disable bits gate disk, serial bus, dma hits
// - boot rom window hits are claimed with medium timing
// - port is a 32-bit multiplexed address/data pci interface
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module pcd_claim_decode #(
  parameter int unsigned CNT_W = 16
) (
  // clock and reset
  input  wire logic                       CLK,
  input  wire logic                       RESET,
  // apb slave
  input  wire logic                       PSEL,
  input  wire logic                       PENABLE,
  input  wire logic                       PWRITE,
  input  wire logic [pcd_pkg::APB_AW-1:0] PADDR,
  input  wire logic [31:0]                PWDATA,
  output logic      [31:0]                PRDATA,
  output logic                            PREADY,
  output logic                            PSLVERR,
  // pci bus, target side
  input  wire logic                       FRAME_L,
  input  wire logic                       IRDY_L,
  input  wire logic [31:0]                AD,
  input  wire logic [3:0]                 CBE_L,
  input  wire logic                       IDSEL,
  input  wire logic                       DEVSEL_L_I,
  output logic                            DEVSEL_L_O,
  output logic                            DEVSEL_L_OE,
  // hits from internal decoders
  input  wire pcd_pkg::pcd_hit_s          HITS,
  // claim report to the data path
  output logic                            CLAIMED,
  output logic                            CLAIM_SUBTRACTIVE,
  output logic [1:0]                      SUB_PATH
);
  import pcd_pkg::*;

  if (CNT_W < 1 || CNT_W > 16) begin : g_chk
    $error("CNT_W must be 1 to 16");
  end

  pcd_state_e      st_q;
  pcd_state_e      st_d;
  pcd_aphase_s     ap_q;
  logic [1:0]      cyc_q;
  logic            devsel_q;
  logic            devsel_d;
  logic [31:0]     ctl_q;
  logic [31:0]     rom_q;
  logic            last_sub_q;
  logic            last_med_q;
  logic [CNT_W-1:0] med_cnt_q;
  logic [CNT_W-1:0] sub_cnt_q;

  // decode terms; command, address and idsel come from the latched address phase, bus and devsel state are live
  logic            bus_idle;
  logic            med_strobe;
  logic            sub_strobe;
  logic            devsel_seen;
  logic            is_special;
  logic            is_io_mem;
  logic            is_mem;
  logic            is_cfg;
  logic            cfg_fn0;
  logic            cfg_fn1;
  logic            cfg_fn3;
  logic            cfg_fn4;
  logic            rom_hit;
  logic            med_hit;
  logic            sub_ok;
  logic            claim_med;
  logic            claim_sub;
  logic            claim_start;

  assign bus_idle    = FRAME_L & IRDY_L;
  assign med_strobe  = (st_q == ST_DECODE) && (cyc_q == MED_STROBE_CYC);
  assign sub_strobe  = (st_q == ST_DECODE) && (cyc_q == SUB_STROBE_CYC);
  // another agent's devsel also blocks a subtractive claim
  assign devsel_seen = devsel_q | ~DEVSEL_L_I;

  assign is_special = (ap_q.cmd == CMD_SPECIAL);
  assign is_mem     = (ap_q.cmd == CMD_MEM_RD)    || (ap_q.cmd == CMD_MEM_WR)   ||
                      (ap_q.cmd == CMD_MEM_RDMUL) || (ap_q.cmd == CMD_MEM_RDLN) ||
                      (ap_q.cmd == CMD_MEM_WRINV);
  assign is_io_mem  = is_mem || (ap_q.cmd == CMD_IO_RD) || (ap_q.cmd == CMD_IO_WR);
  assign is_cfg     = (ap_q.cmd == CMD_CFG_RD) || (ap_q.cmd == CMD_CFG_WR);

  logic            cfg_to_me;
  // type 0 config to this device, selected by idsel
  assign cfg_to_me = is_cfg && ap_q.idsel && (ap_q.addr[1:0] == 2'b00);
  assign cfg_fn0   = cfg_to_me && (ap_q.addr[10:8] == FN_0);
  assign cfg_fn1   = cfg_to_me && (ap_q.addr[10:8] == FN_1);
  assign cfg_fn3   = cfg_to_me && (ap_q.addr[10:8] == FN_3);
  assign cfg_fn4   = cfg_to_me && (ap_q.addr[10:8] == FN_4);

  assign rom_hit = is_mem &&
                   ((ap_q.addr[31:16] & rom_q[ROM_MASK_LSB +: 16]) ==
                    (rom_q[ROM_BASE_LSB +: 16] & rom_q[ROM_MASK_LSB +: 16]));

  // medium window terms; dma, disk and serial bus hits each gated by its own disable bit
  logic            med_intack;
  logic            med_dma;
  logic            med_disk;
  logic            med_ser;
  logic            med_cfg;
  assign med_intack = (ap_q.cmd == CMD_INT_ACK);
  assign med_dma    = HITS.dma_ctrl_hit & ~ctl_q[CTL_DMA_DIS_BIT];
  assign med_disk   = HITS.disk_ctrl_hit & ~ctl_q[CTL_DISK_DIS_BIT];
  assign med_ser    = HITS.serial_bus_ctrl_hit & ~ctl_q[CTL_SER_DIS_BIT];
  // functions 0 and 3 carry no disable bit
  assign med_cfg    = cfg_fn0 | cfg_fn3
                    | (cfg_fn1 & ~ctl_q[CTL_DISK_DIS_BIT])
                    | (cfg_fn4 & ~ctl_q[CTL_SER_DIS_BIT]);
  assign med_hit    = med_intack | HITS.legacy_device_hit | med_dma
                    | med_disk | med_ser | med_cfg | rom_hit;

  assign sub_ok      = ~ctl_q[CTL_SUB_MSB];
  assign claim_med   = med_strobe & ~devsel_seen & med_hit;
  assign claim_sub   = sub_strobe & ~devsel_seen & is_io_mem & sub_ok;
  assign claim_start = ~is_special & (claim_med | claim_sub);                 // and

  // transaction tracking
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (!FRAME_L) begin
          st_d = ST_DECODE;
        end
      end
      ST_DECODE: begin
        if (claim_start) begin
          st_d = ST_CLAIMED;
        end else if (bus_idle) begin
          st_d = ST_IDLE;
        end else if (sub_strobe) begin
          st_d = ST_UNCLAIMED;
        end
      end
      ST_CLAIMED: begin
        // no decision is taken again until the bus goes idle
        if (bus_idle) begin
          st_d = ST_IDLE;
        end
      end
      ST_UNCLAIMED: begin
        if (bus_idle) begin
          st_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // address phase capture, 32-bit multiplexed ad bus
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ap_q <= '0;
    end else if (st_q == ST_IDLE && !FRAME_L) begin
      ap_q <= '{cmd: CBE_L, addr: AD, idsel: IDSEL};                          // and
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      cyc_q <= 2'd0;
    end else if (st_q != ST_DECODE) begin
      cyc_q <= 2'd0;
    end else if (cyc_q != SUB_STROBE_CYC) begin
      cyc_q <= cyc_q + 2'd1;
    end
  end

  // devsel held from the claim until the bus is idle
  always_comb begin
    devsel_d = devsel_q;
    if (claim_start) begin
      devsel_d = 1'b1;
    end else if (bus_idle) begin
      devsel_d = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      devsel_q <= 1'b0;
    end else begin
      devsel_q <= devsel_d;
    end
  end

  // one extra cycle driving high so the line is not left floating low
  always_ff @(posedge CLK) begin
    if (RESET) begin
      DEVSEL_L_O  <= 1'b1;
      DEVSEL_L_OE <= 1'b0;
    end else begin
      DEVSEL_L_O  <= ~devsel_d;
      DEVSEL_L_OE <= devsel_d | devsel_q;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      CLAIMED           <= 1'b0;
      CLAIM_SUBTRACTIVE <= 1'b0;
    end else begin
      CLAIMED           <= devsel_d;
      if (claim_start) begin
        CLAIM_SUBTRACTIVE <= claim_sub;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      SUB_PATH <= CTL_RESET[CTL_SUB_MSB:CTL_SUB_LSB];
    end else begin
      SUB_PATH <= ctl_q[CTL_SUB_MSB:CTL_SUB_LSB];
    end
  end

  // apb: one wait state, then pready for one cycle
  logic apb_acc;
  logic apb_do;
  logic apb_map;
  assign apb_acc = PSEL & PENABLE & ~PREADY;
  assign apb_do  = PSEL & PENABLE & PREADY;
  assign apb_map = (PADDR == OFS_DECODE_CTRL) || (PADDR == OFS_BOOT_ROM) ||
                   (PADDR == OFS_STATUS)      || (PADDR == OFS_CLAIM_CNT);

  // read words built from package field positions
  logic [15:0]     med_cnt_w;
  logic [15:0]     sub_cnt_w;
  logic [31:0]     status_word;
  logic [31:0]     count_word;
  logic [31:0]     rd_word;
  assign med_cnt_w = 16'(med_cnt_q);
  assign sub_cnt_w = 16'(sub_cnt_q);

  always_comb begin
    status_word              = 32'h0000_0000;
    status_word[ST_BUSY_BIT] = devsel_q;
    status_word[ST_LSUB_BIT] = last_sub_q;
    status_word[ST_LMED_BIT] = last_med_q;
    status_word[ST_WIN_BIT]  = (st_q == ST_DECODE);
  end

  always_comb begin
    count_word                    = 32'h0000_0000;
    count_word[15:0]              = med_cnt_w;
    count_word[CNT_SUB_LSB +: 16] = sub_cnt_w;
  end

  // unmapped offsets read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (PADDR)
      OFS_DECODE_CTRL: rd_word = ctl_q;
      OFS_BOOT_ROM:    rd_word = rom_q;
      OFS_STATUS:      rd_word = status_word;
      OFS_CLAIM_CNT:   rd_word = count_word;
      default:         rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= apb_acc;
      PSLVERR <= apb_acc & ~apb_map;
      PRDATA  <= 32'h0000_0000;
      if (apb_acc && !PWRITE) begin
        PRDATA <= rd_word;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctl_q <= CTL_RESET;
      rom_q <= ROM_RESET;
    end else if (apb_do && PWRITE) begin
      if (PADDR == OFS_DECODE_CTRL) begin
        ctl_q <= PWDATA & CTL_WMASK;
      end
      if (PADDR == OFS_BOOT_ROM) begin
        rom_q <= PWDATA;
      end
    end
  end

  // claim statistics; a claim in the clearing cycle is still counted
  logic cnt_clr;
  assign cnt_clr = apb_do & PWRITE & (PADDR == OFS_CLAIM_CNT);

  always_ff @(posedge CLK) begin
    if (RESET) begin
      last_med_q <= 1'b0;
      last_sub_q <= 1'b0;
    end else if (claim_start) begin
      last_med_q <= claim_med;
      last_sub_q <= claim_sub;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      med_cnt_q <= '0;
      sub_cnt_q <= '0;
    end else begin
      if (cnt_clr) begin
        med_cnt_q <= CNT_W'(claim_start & claim_med);
        sub_cnt_q <= CNT_W'(claim_start & claim_sub);
      end else if (claim_start) begin
        if (claim_med) begin
          med_cnt_q <= med_cnt_q + CNT_W'(1);
        end else begin
          sub_cnt_q <= sub_cnt_q + CNT_W'(1);
        end
      end
    end
  end

endmodule

`default_nettype wire

// ### rtl/pcd_pkg.sv
// constants, types and register map of the pci target claim decoder
package pcd_pkg;

  // register byte offsets on the apb side
  localparam int unsigned     APB_AW          = 12;
  localparam logic [11:0]     OFS_DECODE_CTRL = 12'h000;
  localparam logic [11:0]     OFS_BOOT_ROM    = 12'h004;
  localparam logic [11:0]     OFS_STATUS      = 12'h008;
  localparam logic [11:0]     OFS_CLAIM_CNT   = 12'h00C;

  // decode_control_reg fields
  localparam int unsigned     CTL_DMA_DIS_BIT  = 0;
  localparam int unsigned     CTL_DISK_DIS_BIT = 1;
  localparam int unsigned     CTL_SER_DIS_BIT  = 2;
  localparam int unsigned     CTL_SUB_LSB      = 4;
  localparam int unsigned     CTL_SUB_MSB      = 5;
  localparam logic [31:0]     CTL_RESET        = 32'h0000_0000;
  localparam logic [31:0]     CTL_WMASK        = 32'h0000_0037;

  // boot_rom_range_reg: base in [15:0], mask in [31:16], both against address bits 31:16
  localparam int unsigned     ROM_BASE_LSB = 0;
  localparam int unsigned     ROM_MASK_LSB = 16;
  localparam logic [31:0]     ROM_RESET    = 32'hFFF0_FFF0;

  // status fields
  localparam int unsigned     ST_BUSY_BIT  = 0;
  localparam int unsigned     ST_LSUB_BIT  = 1;
  localparam int unsigned     ST_LMED_BIT  = 2;
  localparam int unsigned     ST_WIN_BIT   = 3;
  localparam int unsigned     CNT_SUB_LSB  = 16;

  // command codes as carried on the c/be lines in the address phase
  localparam logic [3:0]      CMD_INT_ACK   = 4'h0;
  localparam logic [3:0]      CMD_SPECIAL   = 4'h1;
  localparam logic [3:0]      CMD_IO_RD     = 4'h2;
  localparam logic [3:0]      CMD_IO_WR     = 4'h3;
  localparam logic [3:0]      CMD_MEM_RD    = 4'h6;
  localparam logic [3:0]      CMD_MEM_WR    = 4'h7;
  localparam logic [3:0]      CMD_CFG_RD    = 4'hA;
  localparam logic [3:0]      CMD_CFG_WR    = 4'hB;
  localparam logic [3:0]      CMD_MEM_RDMUL = 4'hC;
  localparam logic [3:0]      CMD_MEM_RDLN  = 4'hE;
  localparam logic [3:0]      CMD_MEM_WRINV = 4'hF;

  // own configuration function numbers
  localparam logic [2:0]      FN_0 = 3'h0;
  localparam logic [2:0]      FN_1 = 3'h1;
  localparam logic [2:0]      FN_3 = 3'h3;
  localparam logic [2:0]      FN_4 = 3'h4;

  // strobe positions in cycles after the address phase
  localparam logic [1:0]      MED_STROBE_CYC = 2'd1;
  localparam logic [1:0]      SUB_STROBE_CYC = 2'd3;

  typedef enum logic [1:0] {ST_IDLE, ST_DECODE, ST_CLAIMED, ST_UNCLAIMED} pcd_state_e;

  // decode hits from the internal target decoders
  typedef struct packed {
    logic legacy_device_hit;
    logic dma_ctrl_hit;
    logic disk_ctrl_hit;
    logic serial_bus_ctrl_hit;
  } pcd_hit_s;

  // address phase capture
  typedef struct packed {
    logic [3:0]  cmd;
    logic [31:0] addr;
    logic        idsel;
  } pcd_aphase_s;

endpackage
